// ===== logic/plcs_regs.sv
// link control/status and slot feature register bank behind an axi4-lite slave
//
// Functional notes
// - power state field: 00 none, 01 L0s only, 10 L1 only, 11 both; resets 00.
// - receiver may always enter L0s, whatever the power state field says.
// - completion split boundary bit: 0 gives 64 bytes, 1 gives 128 bytes.
// - reverse mode: link disable bit set takes the link down, clear lets it run.
// - forward mode: disable, retrain, error and training bits read zero, ignore writes.
// - reverse mode: writing 1 to retrain starts retraining; the bit always reads 0.
// - shared reference clock bit records asynchronous (0) or common (1) clocking.
// - extended sync: 4096 FTS then one SKIP leaving L0s, 1024 TS1 in Recovery.
// - current speed field always reads 1h, a 2.5 Gbps link.
// - negotiated width reads x1, x2 or x4 codes only; x4 by default.
// - reverse mode: training error flag reads 1 when training error detected.
// - reverse mode: training flag reads 1 while requested training pends or runs.
// - slot clock bit: 0 independent clock, 1 platform connector reference clock.
// - slot feature bits 0..3 are straps in reverse mode, read 0 forward.
`timescale 1ns/1ps
`include "plcs_map.svh"
module plcs_regs (
  input wire logic aclk, // core clock, 50 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [`PLCS_AW-1:0] s_axi_awaddr, // write address
  input wire logic [2:0] s_axi_awprot, // unused protection
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [`PLCS_AW-1:0] s_axi_araddr, // read address
  input wire logic [2:0] s_axi_arprot, // unused protection
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire plcs_pkg::plcs_link_stat_t link_stat, // pins from training logic and straps
  output plcs_pkg::plcs_link_cmd_t link_cmd, // commands to training logic
  output logic irq // level interrupt, active high
);
  import plcs_pkg::*;

  // word-aligned decode shared by read and write paths
  function automatic logic [1:0] reg_sel(input logic [`PLCS_AW-1:0] a);
    unique case ({a[`PLCS_AW-1:2], 2'b00})
      `PLCS_OFF_LINK: reg_sel = 2'h0;
      `PLCS_OFF_SLOT: reg_sel = 2'h1;
      `PLCS_OFF_IRQ_STAT: reg_sel = 2'h2;
      `PLCS_OFF_IRQ_MASK: reg_sel = 2'h3;
      default: reg_sel = 2'h0;
    endcase
  endfunction

  function automatic logic is_mapped(input logic [`PLCS_AW-1:0] a);
    logic [`PLCS_AW-1:0] w;
    w = {a[`PLCS_AW-1:2], 2'b00};
    is_mapped = (w == `PLCS_OFF_LINK) || (w == `PLCS_OFF_SLOT) ||
                (w == `PLCS_OFF_IRQ_STAT) || (w == `PLCS_OFF_IRQ_MASK);
  endfunction

  plcs_link_stat_t stat_meta_r;
  plcs_link_stat_t stat_r;
  logic init_done_r;
  logic rev_r;
  logic slot_clk_r;
  logic [3:0] slot_caps_r;
  logic busy_d_r;
  logic terr_d_r;
  logic lup_d_r;
  plcs_ctrl_t ctrl_r;
  logic [5:0] width_r;
  logic train_pend_r;
  logic [`PLCS_IRQ_W-1:0] irq_stat_r;
  logic [`PLCS_IRQ_W-1:0] irq_stat_nxt;
  logic [`PLCS_IRQ_W-1:0] irq_mask_r;
  logic [`PLCS_IRQ_W-1:0] irq_ev;
  logic aw_held_r;
  logic w_held_r;
  logic [`PLCS_AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  logic wr_link;
  logic retrain_req;
  logic train_flag;
  logic [31:0] rd_word;

  // two-stage synchroniser, left out of reset so straps are through it at release
  always_ff @(posedge aclk) begin
    stat_meta_r <= link_stat;
    stat_r <= stat_meta_r;
  end

  // straps caught once after reset release; later pin motion is ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      init_done_r <= 1'b0;
      rev_r <= 1'b0;
      slot_clk_r <= 1'b0;
      slot_caps_r <= 4'h0;
    end else if (!init_done_r) begin
      init_done_r <= 1'b1;
      rev_r <= stat_r.reverse_mode;
      slot_clk_r <= stat_r.slot_clk;
      slot_caps_r <= stat_r.slot_caps;
    end
  end

  // delayed copies track the pins through reset, so release shows no false edge
  always_ff @(posedge aclk) begin
    busy_d_r <= stat_r.training_busy;
    terr_d_r <= stat_r.training_err;
    lup_d_r <= stat_r.link_up;
  end

  // write path: address and data taken in either order, then one response
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_link = wr_go && is_mapped(awaddr_r) && (reg_sel(awaddr_r) == 2'h0) && wstrb_r[0];
  // retrain only acts in reverse mode
  assign retrain_req = wr_link && rev_r && wdata_r[`PLCS_B_RETRAIN];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // ready only while the slot is empty, so a response never gets overrun
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PLCS_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(awaddr_r) ? `PLCS_RESP_OKAY : `PLCS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // link control fields; only byte lane 0 holds writable bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r.active_power_state_control <= `PLCS_PWR_RST;
      ctrl_r.completion_split_boundary <= 1'b0;
      ctrl_r.ldis <= 1'b0;
      ctrl_r.ccc <= 1'b0;
      ctrl_r.esync <= 1'b0;
    end else if (wr_link) begin
      ctrl_r.active_power_state_control <= wdata_r[`PLCS_B_PWR_HI:`PLCS_B_PWR_LO];
      ctrl_r.completion_split_boundary <= wdata_r[`PLCS_B_SPLIT];
      ctrl_r.ldis <= rev_r & wdata_r[`PLCS_B_LDIS];
      ctrl_r.ccc <= wdata_r[`PLCS_B_CCC];
      ctrl_r.esync <= wdata_r[`PLCS_B_ESYNC];
    end
  end

  // only legal codes are kept; last value held while link is down
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      width_r <= `PLCS_W_X4;
    end else if (stat_r.link_up && (stat_r.neg_width == `PLCS_W_X1 ||
               stat_r.neg_width == `PLCS_W_X2 || stat_r.neg_width == `PLCS_W_X4)) begin
      width_r <= stat_r.neg_width;
    end
  end

  // pending flag bridges the gap before the trainer shows busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      train_pend_r <= 1'b0;
    end else if (retrain_req) begin
      train_pend_r <= 1'b1;
    end else if (stat_r.training_busy) begin
      train_pend_r <= 1'b0;
    end
  end
  assign train_flag = rev_r && (train_pend_r || stat_r.training_busy);

  // link commands, all from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_cmd <= '0;
    end else begin
      link_cmd.tx_l0s_en <= ctrl_r.active_power_state_control[0];
      link_cmd.tx_l1_en <= ctrl_r.active_power_state_control[1];
      link_cmd.rx_l0s_en <= 1'b1;
      link_cmd.split_128 <= ctrl_r.completion_split_boundary;
      link_cmd.link_disable <= rev_r & ctrl_r.ldis;
      link_cmd.retrain <= retrain_req;
      link_cmd.common_clk <= ctrl_r.ccc;
      link_cmd.ext_sync <= ctrl_r.esync;
      link_cmd.fts_count <= ctrl_r.esync ? `PLCS_FTS_EXT : `PLCS_FTS_STD;
      link_cmd.ts1_count <= ctrl_r.esync ? `PLCS_TS1_EXT : `PLCS_TS1_STD;
    end
  end

  // interrupt events from synchronised status edges
  always_comb begin
    irq_ev = '0;
    irq_ev[`PLCS_IRQ_TERR] = rev_r && stat_r.training_err && !terr_d_r;
    irq_ev[`PLCS_IRQ_TDONE] = busy_d_r && !stat_r.training_busy;
    irq_ev[`PLCS_IRQ_LUP] = stat_r.link_up && !lup_d_r;
  end

  // set wins over a write-one clear in the same cycle
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (wr_go && is_mapped(awaddr_r) && reg_sel(awaddr_r) == 2'h2 && wstrb_r[0]) begin
      irq_stat_nxt = irq_stat_r & ~wdata_r[`PLCS_IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_ev;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
      irq <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_go && is_mapped(awaddr_r) && reg_sel(awaddr_r) == 2'h3 && wstrb_r[0]) begin
        irq_mask_r <= wdata_r[`PLCS_IRQ_W-1:0];
      end
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read word assembly; unlisted bits stay zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (reg_sel(s_axi_araddr))
      2'h0: begin
        rd_word[`PLCS_B_PWR_HI:`PLCS_B_PWR_LO] = ctrl_r.active_power_state_control;
        rd_word[`PLCS_B_SPLIT] = ctrl_r.completion_split_boundary;
        rd_word[`PLCS_B_LDIS] = rev_r & ctrl_r.ldis;
        // retrain reads zero, left at default
        rd_word[`PLCS_B_CCC] = ctrl_r.ccc;
        rd_word[`PLCS_B_ESYNC] = ctrl_r.esync;
        rd_word[`PLCS_B_SPEED_HI:`PLCS_B_SPEED_LO] = `PLCS_SPEED_2G5;
        rd_word[`PLCS_B_WIDTH_HI:`PLCS_B_WIDTH_LO] = width_r;
        rd_word[`PLCS_B_TERR] = rev_r & stat_r.training_err;
        rd_word[`PLCS_B_TRAIN] = train_flag;
        rd_word[`PLCS_B_SLOTCLK] = slot_clk_r;
      end
      2'h1: rd_word[3:0] = rev_r ? slot_caps_r : 4'h0;
      2'h2: rd_word[`PLCS_IRQ_W-1:0] = irq_stat_r;
      2'h3: rd_word[`PLCS_IRQ_W-1:0] = irq_mask_r;
    endcase
    if (!is_mapped(s_axi_araddr)) begin
      rd_word = 32'h0000_0000;
    end
  end

  // read path: one outstanding read, data held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PLCS_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= is_mapped(s_axi_araddr) ? `PLCS_RESP_OKAY : `PLCS_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks on the register behaviour
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic rd_link;
  logic rd_slot;
  assign rd_link = s_axi_arvalid && s_axi_arready && is_mapped(s_axi_araddr) &&
                   reg_sel(s_axi_araddr) == 2'h0;
  assign rd_slot = s_axi_arvalid && s_axi_arready && is_mapped(s_axi_araddr) &&
                   reg_sel(s_axi_araddr) == 2'h1;

  a_pwr_l0s_only: assert property (
    wr_link && wdata_r[1:0] == 2'b01 |=> ##1 link_cmd.tx_l0s_en && !link_cmd.tx_l1_en)
    else $error("power state 01 did not give L0s only");
  a_rx_l0s_allowed: assert property (
    init_done_r |-> link_cmd.rx_l0s_en)
    else $error("receiver L0s not allowed");
  a_split_follows: assert property (
    wr_link |=> ##1 link_cmd.split_128 == $past(wdata_r[`PLCS_B_SPLIT], 2))
    else $error("boundary select not applied");
  a_ldis_reverse: assert property (
    wr_link && rev_r && wdata_r[`PLCS_B_LDIS] |=> ##1 link_cmd.link_disable)
    else $error("link disable not applied");
  a_fwd_zero_bits: assert property (
    rd_link && !rev_r |=> s_axi_rdata[27:26] == 2'b00 && s_axi_rdata[5:4] == 2'b00)
    else $error("forward mode bits not zero");
  a_retrain_pulse: assert property (
    retrain_req |=> link_cmd.retrain ##1 !link_cmd.retrain)
    else $error("retrain pulse wrong");
  a_retrain_reads0: assert property (
    rd_link |=> !s_axi_rdata[`PLCS_B_RETRAIN])
    else $error("retrain bit read as one");
  a_esync_counts: assert property (
    ctrl_r.esync && $stable(ctrl_r.esync) |=>
      link_cmd.fts_count == 13'h1000 && link_cmd.ts1_count == 11'h400)
    else $error("extended sync counts wrong");
  a_speed_fixed: assert property (
    rd_link |=> s_axi_rdata[19:16] == 4'h1)
    else $error("speed field not 1h");
  a_width_legal: assert property (
    width_r == 6'h01 || width_r == 6'h02 || width_r == 6'h04)
    else $error("illegal width code");
  a_train_flag: assert property (
    retrain_req |=> train_flag[*2])
    else $error("training flag not raised");
  a_slot_fwd_zero: assert property (
    rd_slot && !rev_r |=> s_axi_rdata == 32'h0000_0000)
    else $error("slot bits not zero in forward mode");
  a_reserved_zero: assert property (
    rd_link |=> s_axi_rdata[2] == 1'b0 && s_axi_rdata[15:8] == 8'h00 &&
      s_axi_rdata[31:29] == 3'h0)
    else $error("reserved bits not zero");

  c_link_write: cover property (wr_link);
  c_retrain: cover property (retrain_req ##[1:20] stat_r.training_busy);
  c_slot_read: cover property (rd_slot && rev_r);
  c_irq_raised: cover property (!irq ##1 irq);
endmodule

// ===== pkg/plcs_map.svh
// register offsets, field positions, reset values and ordered-set counts
`ifndef PLCS_MAP_SVH
`define PLCS_MAP_SVH
`define PLCS_AW 12
`define PLCS_OFF_LINK 12'h078
`define PLCS_OFF_SLOT 12'h07c
`define PLCS_OFF_IRQ_STAT 12'h090
`define PLCS_OFF_IRQ_MASK 12'h094
`define PLCS_B_PWR_LO 0
`define PLCS_B_PWR_HI 1
`define PLCS_B_SPLIT 3
`define PLCS_B_LDIS 4
`define PLCS_B_RETRAIN 5
`define PLCS_B_CCC 6
`define PLCS_B_ESYNC 7
`define PLCS_B_SPEED_LO 16
`define PLCS_B_SPEED_HI 19
`define PLCS_B_WIDTH_LO 20
`define PLCS_B_WIDTH_HI 25
`define PLCS_B_TERR 26
`define PLCS_B_TRAIN 27
`define PLCS_B_SLOTCLK 28
`define PLCS_SPEED_2G5 4'h1
`define PLCS_W_X1 6'h01
`define PLCS_W_X2 6'h02
`define PLCS_W_X4 6'h04
`define PLCS_PWR_RST 2'h0
`define PLCS_IRQ_W 3
`define PLCS_IRQ_TERR 0
`define PLCS_IRQ_TDONE 1
`define PLCS_IRQ_LUP 2
`define PLCS_FTS_EXT 13'h1000
`define PLCS_FTS_STD 13'h0080
`define PLCS_TS1_EXT 11'h400
`define PLCS_TS1_STD 11'h010
`define PLCS_RESP_OKAY 2'h0
`define PLCS_RESP_SLVERR 2'h2
`endif

// ===== pkg/plcs_pkg.sv
// types shared by the link control and status register bank
package plcs_pkg;
  // commands driven toward the link training logic
  typedef struct packed {
    logic tx_l0s_en;
    logic tx_l1_en;
    logic rx_l0s_en;
    logic split_128;
    logic link_disable;
    logic retrain;
    logic common_clk;
    logic ext_sync;
    logic [12:0] fts_count;
    logic [10:0] ts1_count;
  } plcs_link_cmd_t;
  // status and straps arriving from pins
  typedef struct packed {
    logic reverse_mode;
    logic training_err;
    logic training_busy;
    logic link_up;
    logic [5:0] neg_width;
    logic slot_clk;
    logic [3:0] slot_caps;
  } plcs_link_stat_t;
  // software-held link control fields
  typedef struct packed {
    logic [1:0] active_power_state_control;
    logic completion_split_boundary;
    logic ldis;
    logic ccc;
    logic esync;
  } plcs_ctrl_t;
endpackage

// ===== verif/plcs_link_partner.sv
// link partner model: training runs, link state and strap pins
`timescale 1ns/1ps
module plcs_link_partner (
  input wire logic aclk, // core clock
  input wire plcs_pkg::plcs_link_cmd_t link_cmd, // commands from the bank
  input wire logic rev, // strap, reverse mode
  input wire logic err, // training error level
  input wire logic sclk, // strap, slot clock
  input wire logic [3:0] caps, // straps, slot features
  input wire logic [5:0] width, // width agreed on the link
  input wire logic slow, // long training runs
  output plcs_pkg::plcs_link_stat_t link_stat // pins toward the bank
);
  import plcs_pkg::*;
  logic busy_r = 1'h0;
  logic up_r = 1'h1;
  logic dis_q = 1'h0;
  int cnt = 0;
  // retrain pulse or disable release starts a run; link is down meanwhile
  always @(posedge aclk) begin
    dis_q <= link_cmd.link_disable;
    if (link_cmd.link_disable) begin
      busy_r <= 1'h0;
      up_r <= 1'h0;
    end else if (link_cmd.retrain || dis_q) begin
      busy_r <= 1'h1;
      up_r <= 1'h0;
      cnt <= slow ? 20 : 3;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (busy_r) begin
      busy_r <= 1'h0;
      up_r <= 1'h1;
    end
  end
  // width lanes carry no meaning while down, so show a wrong pattern
  assign link_stat = {rev, err, busy_r, up_r, (up_r ? width : ~width), sclk, caps};
endmodule

// ===== verif/plcs_regs_tb.sv
// self-checking bench for the link control and status register bank
`timescale 1ns/1ps
`include "plcs_map.svh"
module plcs_regs_tb;
  import plcs_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  plcs_link_stat_t link_stat;
  plcs_link_cmd_t link_cmd;
  logic rev = 1'h1, err = 1'h0, sclk = 1'h1, slow = 1'h0;
  logic [3:0] caps = 4'h0;
  logic [5:0] width = `PLCS_W_X2;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [7:0] c;
  logic [5:0] wv[3] = '{6'h01, 6'h03, 6'h04};
  logic [5:0] ev[3] = '{6'h01, 6'h01, 6'h04};
  int error_cnt = 0, n_compared = 0, n_retrain = 0;

  always #10 aclk = ~aclk;

  plcs_regs plcs_regs_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_stat(link_stat),
    .link_cmd(link_cmd), .irq(irq));

  plcs_link_partner plcs_link_partner_i (.aclk(aclk), .link_cmd(link_cmd), .rev(rev),
    .err(err), .sclk(sclk), .caps(caps), .width(width), .slow(slow), .link_stat(link_stat));

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // monitor: every answer taken off the bus meets the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'h1 && rready === 1'h1 && rq.size() > 0) begin
      check("rdata", {rresp, rdata}, rq.pop_front());
    end
    if (bvalid === 1'h1 && bready === 1'h1 && bq.size() > 0) begin
      check("bresp", 34'(bresp), 34'(bq.pop_front()));
    end
  end

  // retrain is a pulse, so count its cycles rather than sample it
  always @(posedge aclk) begin
    if (link_cmd.retrain === 1'h1) n_retrain++;
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'h0;
    w_done = 1'h0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= {3'($urandom), 1'h1};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // each channel released at its own handshake edge
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready === 1'h1 && !aw_done) begin
        aw_done = 1'h1;
        awvalid <= 1'h0;
      end
      if (wready === 1'h1 && !w_done) begin
        w_done = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'h1);
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge aclk); while (rvalid !== 1'h1);
    rready <= 1'h0;
  endtask

  // expected link word; st is slot clock, training, error
  task automatic rdl(input logic [7:0] ctl, input logic [5:0] w, input logic [2:0] st);
    rd(`PLCS_OFF_LINK, {5'h0, st, w, `PLCS_SPEED_2G5, 8'h0, ctl & 8'hdb});
  endtask

  function automatic plcs_link_cmd_t ecmd(input logic [7:0] x);
    ecmd = {x[0], x[1], 1'h1, x[3], x[4], 1'h0, x[6], x[7],
      (x[7] ? `PLCS_FTS_EXT : `PLCS_FTS_STD), (x[7] ? `PLCS_TS1_EXT : `PLCS_TS1_STD)};
  endfunction

  task automatic settle();
    @(posedge aclk);
    #1;
  endtask

  // straps change well before release and stay put after it
  task automatic do_reset(input logic r);
    @(posedge aclk);
    aresetn <= 1'h0;
    rev <= r;
    sclk <= r;
    caps <= 4'($urandom);
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (6) @(posedge aclk);
    wr(`PLCS_OFF_IRQ_STAT, 32'h7, `PLCS_RESP_OKAY);
  endtask

  initial begin
    void'($urandom(2));
    do_reset(1'h1);
    check("cmd_rst", 34'(link_cmd), 34'(ecmd(8'h0)));
    rd(`PLCS_OFF_SLOT, 34'(caps));
    rd(`PLCS_OFF_IRQ_MASK, 34'h0);
    rdl(8'h0, `PLCS_W_X2, 3'h4);
    // every power state code, with reserved bits written as ones
    for (int i = 0; i < 4; i++) begin
      c = (8'($urandom) & 8'hc8) | 8'(i);
      wr(`PLCS_OFF_LINK, {24'hffffff, c | 8'h04}, `PLCS_RESP_OKAY);
      settle();
      check("cmd", 34'(link_cmd), 34'(ecmd(c)));
      rdl(c, `PLCS_W_X2, 3'h4);
    end
    for (int i = 0; i < 3; i++) begin
      width <= wv[i];
      repeat (5) @(posedge aclk);
      rdl(c, ev[i], 3'h4);
    end
    // slow training: flag stays up until the run ends
    slow <= 1'h1;
    wr(`PLCS_OFF_LINK, 32'(c | 8'h20), `PLCS_RESP_OKAY);
    rdl(c, `PLCS_W_X4, 3'h6);
    check("retrain", 34'(n_retrain), 34'h1);
    repeat (40) @(posedge aclk);
    rdl(c, `PLCS_W_X4, 3'h4);
    rd(`PLCS_OFF_IRQ_STAT, 34'h6);
    // events pending but masked: line stays low until the mask opens
    check("irq_masked", 34'(irq), 34'h0);
    wr(`PLCS_OFF_IRQ_MASK, 32'h7, `PLCS_RESP_OKAY);
    settle();
    check("irq", 34'(irq), 34'h1);
    wr(`PLCS_OFF_IRQ_STAT, 32'h7, `PLCS_RESP_OKAY);
    settle();
    check("irq_clr", 34'(irq), 34'h0);
    wr(`PLCS_OFF_IRQ_MASK, 32'h0, `PLCS_RESP_OKAY);
    // disable then release, prompt partner
    slow <= 1'h0;
    wr(`PLCS_OFF_LINK, 32'(c | 8'h10), `PLCS_RESP_OKAY);
    settle();
    check("cmd_dis", 34'(link_cmd), 34'(ecmd(c | 8'h10)));
    rdl(c | 8'h10, `PLCS_W_X4, 3'h4);
    wr(`PLCS_OFF_LINK, 32'(c), `PLCS_RESP_OKAY);
    repeat (12) @(posedge aclk);
    rdl(c, `PLCS_W_X4, 3'h4);
    rd(`PLCS_OFF_IRQ_STAT, 34'h6);
    wr(`PLCS_OFF_IRQ_STAT, 32'h7, `PLCS_RESP_OKAY);
    err <= 1'h1;
    repeat (5) @(posedge aclk);
    rdl(c, `PLCS_W_X4, 3'h5);
    rd(`PLCS_OFF_IRQ_STAT, 34'h1);
    // unmapped place: write dropped, read zero, both refused
    wr(12'h100, 32'hffffffff, `PLCS_RESP_SLVERR);
    rd(12'h100, {`PLCS_RESP_SLVERR, 32'h0});
    // forward mode: mode-only fields inert, error pin still high
    do_reset(1'h0);
    rd(`PLCS_OFF_SLOT, 34'h0);
    wr(`PLCS_OFF_LINK, 32'hff, `PLCS_RESP_OKAY);
    settle();
    check("cmd_fwd", 34'(link_cmd), 34'(ecmd(8'hef)));
    check("retrain_fwd", 34'(n_retrain), 34'h1);
    rdl(8'hef, `PLCS_W_X4, 3'h0);
    give_verdict();
  end

  // watchdog: the sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    give_verdict();
  end
endmodule
